// file: hdl/gci_regs.svh
// Register offsets, field codes, reset values and timing counts of the customer input block.
// Assumes a 40 MHz system clock and a 32-bit AHB-Lite register bus.
`ifndef GCI_REGS_SVH
`define GCI_REGS_SVH

// ============================================================
// Timing
`define GCI_CLK_HZ 40000000
`define GCI_TICK_S 1
`define GCI_TICK_CYCLES (`GCI_CLK_HZ * `GCI_TICK_S)
`define GCI_DEBOUNCE_US 1000
`define GCI_DEBOUNCE_CYCLES ((`GCI_CLK_HZ / 1000000) * `GCI_DEBOUNCE_US)
`define GCI_LS_TMO_S 10
`define GCI_COOLDOWN_S 300

// ============================================================
// Register offsets
`define GCI_CTRL_OFS 8'h00
`define GCI_CMD_OFS 8'h04
`define GCI_LSTMO_OFS 8'h08
`define GCI_STATUS_OFS 8'h0C
`define GCI_INPUT_OFS 8'h10
`define GCI_OUTPUT_OFS 8'h14

// ============================================================
// Field codes and reset values
`define GCI_CTRL_RST 32'h0000_0000
`define GCI_OP_OFF 2'h0
`define GCI_OP_RUN 2'h1
`define GCI_OP_AUTO 2'h2
`define GCI_SETUP_NONE 2'h0
`define GCI_SETUP_SINGLE 2'h1
`define GCI_SETUP_MULTI 2'h2
`define GCI_CF_WAKE_MASK 4'h6
`define GCI_IN_ACT_HIGH 16'h1800

// ============================================================
// Input bit positions
`define GCI_IN_RSTART 0
`define GCI_IN_ESTOP 1
`define GCI_IN_CF_LSB 2
`define GCI_IN_FRESET 6
`define GCI_IN_IDLE 7
`define GCI_IN_LFUEL 8
`define GCI_IN_RUPT 9
`define GCI_IN_UPGND 10
`define GCI_IN_UPHI 11
`define GCI_IN_LSHI 12
`define GCI_IN_LDEM 13
`define GCI_IN_BINH 14
`define GCI_IN_BPOS 15

`endif

// file: hdl/gci_pkg.sv
// Types and small helpers shared by the customer input block.
// Assumes nothing beyond a SystemVerilog compiler.
package gci_pkg;

  // ============================================================
  // Load demand sequence
  typedef enum logic [2:0] {
    LD_OFF,
    LD_RAMP,
    LD_OPEN,
    LD_COOL,
    LD_STOP
  } gci_ld_state_t;

  // ============================================================
  // Edge helper
  function automatic logic gci_rise(input logic cur, input logic prev);
    return cur & ~prev;
  endfunction

endpackage

// file: hdl/gci_debounce.sv
// Two-stage synchroniser and stability filter for one contact input.
// Assumes the input may change at any time relative to clk.
`timescale 1ns/1ps
module gci_debounce #(
  parameter int CYC = 40000
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic din,
  output logic dout
);
  localparam int CW = $clog2(CYC + 1);
  logic sync1_reg;
  logic sync2_reg;
  logic [CW-1:0] cnt_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
    end else begin
      sync1_reg <= din;
      sync2_reg <= sync1_reg;
    end
  end

  // A level must hold for CYC samples; any bounce restarts the wait.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
      dout <= 1'b1;
    end else if (sync2_reg == dout) begin
      cnt_reg <= '0;
    end else if (cnt_reg == CW'(CYC - 1)) begin
      cnt_reg <= '0;
      dout <= sync2_reg;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end
endmodule

// file: hdl/gci_top.sv
// Customer discrete input handler with an AHB-Lite register slave.
// Assumes pins arrive asynchronously; dormant, load_at_min and load_set_code come from logic on hclk.
// Functional notes
// - Auto plus remote start begins cranking.
// - Reset refused while remote start grounded.
// - Emergency stop shuts down immediately.
// - Customer faults raise alarm or shutdown.
// - Fault reset clears all but emergency stop.
// - Idle input: idle speed, voltage disabled; here only in the manual run position.
// - Low fuel input raises warning.
// - Dormant: wake first, then low fuel.
// - Rupture basin input raises alarm.
// - Form C contact shows any warning.
// - Single-unit: supply level enables synchronizer.
// - Load demand needs multi-unit setup.
// - Single setup: close only with verify grounded.
// - Inhibit input opens or blocks breaker.
// - Grounded position input means breaker closed.
// - Utility parallel: kW set from load-set input.
// - Missing lead-start pulse: warning and backup.
// - Load demand: ramp, open, cool, stop.
// - Emergency stop cleared from panel only.
// - Utility mode needs both inputs together.
//
// The implementer's own choices: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "gci_regs.svh"
module gci_top import gci_pkg::*; #(
  parameter int TICK_CYCLES = `GCI_TICK_CYCLES,
  parameter int DB_CYCLES = `GCI_DEBOUNCE_CYCLES,
  parameter logic [15:0] COOLDOWN_S = 16'(`GCI_COOLDOWN_S)
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic remote_start_n,
  input wire logic estop_n,
  input wire logic [3:0] cust_fault_n,
  input wire logic fault_reset_n,
  input wire logic engine_idle_n,
  input wire logic low_fuel_n,
  input wire logic rupture_basin_n,
  input wire logic util_par_gnd_n,
  input wire logic util_par_hi,
  input wire logic lead_start_hi,
  input wire logic ld_demand_n,
  input wire logic bkr_inhibit_n,
  input wire logic bkr_pos_n,
  input wire logic dormant,
  input wire logic load_at_min,
  input wire logic [9:0] load_set_code,
  output logic crank_start,
  output logic shutdown_now,
  output logic idle_speed,
  output logic volt_enable,
  output logic wake_req,
  output logic warn_contact_no,
  output logic warn_contact_nc,
  output logic sync_enable,
  output logic backup_enable,
  output logic bkr_close_permit,
  output logic bkr_open_cmd,
  output logic util_par_mode,
  output logic load_demand_mode,
  output logic ramp_down_req,
  output logic ld_shutdown,
  output logic [9:0] kw_setpoint
);
  localparam int TW = $clog2(TICK_CYCLES);

  logic [15:0] pin_vec;
  logic [15:0] db_raw;
  logic [15:0] db_in;
  logic [15:0] in_db;
  logic [31:0] ctrl_reg;
  logic [7:0] ls_tmo_reg;
  logic panel_reset_reg;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic [31:0] rd_val;
  logic [TW-1:0] tick_cnt_reg;
  logic tick;
  logic [11:0] status_reg;
  logic [11:0] status_set;
  logic [11:0] status_clr;
  logic freset_prev_reg;
  logic ls_prev_reg;
  logic [7:0] ls_sec_reg;
  logic [15:0] cool_sec_reg;
  gci_ld_state_t ld_state;
  logic [1:0] op_sel;
  logic [1:0] setup_sel;
  logic [3:0] cf_sd_sel;
  logic [3:0] cf_db;
  logic [3:0] cf_gate;
  logic freset_ok;
  logic ls_active;
  logic ls_set;
  logic shut_any;
  logic run_ok;
  logic warn_any;
  logic idle_next;

  // ============================================================
  // Input conditioning
  assign pin_vec = {bkr_pos_n, bkr_inhibit_n, ld_demand_n, lead_start_hi, util_par_hi, util_par_gnd_n,
                    rupture_basin_n, low_fuel_n, engine_idle_n, fault_reset_n, cust_fault_n, estop_n,
                    remote_start_n};
  // High-level pins are flipped so every filter idles high, the level it resets to; otherwise a
  // false lead-start edge would follow reset.
  assign db_in = pin_vec ^ `GCI_IN_ACT_HIGH;

  for (genvar gi = 0; gi < 16; gi++) begin : g_db
    gci_debounce #(.CYC(DB_CYCLES)) u_db (
      .clk(hclk),
      .rst_n(hresetn),
      .din(db_in[gi]),
      .dout(db_raw[gi])
    );
  end

  // Contact inputs count when grounded, the two high-level inputs when raised.
  assign in_db = ~db_raw;

  assign op_sel = ctrl_reg[1:0];
  assign setup_sel = ctrl_reg[3:2];
  assign cf_sd_sel = ctrl_reg[7:4];
  assign cf_db = in_db[`GCI_IN_CF_LSB +: 4];

  // ============================================================
  // Register bus
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_comb begin
    rd_val = 32'h0000_0000;
    case (haddr[7:0])
      `GCI_CTRL_OFS: rd_val = {24'h00_0000, ctrl_reg[7:0]};
      `GCI_LSTMO_OFS: rd_val = {24'h00_0000, ls_tmo_reg};
      `GCI_STATUS_OFS: rd_val = {19'h0_0000, ld_shutdown, status_reg};
      `GCI_INPUT_OFS: rd_val = {16'h0000, in_db};
      `GCI_OUTPUT_OFS: rd_val = {16'h0000, ramp_down_req, load_demand_mode, util_par_mode, bkr_open_cmd,
                                 bkr_close_permit, backup_enable, sync_enable, warn_contact_no, wake_req,
                                 volt_enable, idle_speed, shutdown_now, crank_start, 3'h0};
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // Read data is sampled in the address phase, so a read right behind a write to the same register
  // returns the value from before that write.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata <= 32'h0000_0000;
    end else begin
      wr_pend_reg <= hsel & hready & htrans[1] & hwrite;
      if (hsel & hready & htrans[1]) begin
        wr_addr_reg <= haddr[7:0];
        if (!hwrite) begin
          hrdata <= rd_val;
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= `GCI_CTRL_RST;
      ls_tmo_reg <= 8'(`GCI_LS_TMO_S);
      panel_reset_reg <= 1'b0;
    end else begin
      panel_reset_reg <= 1'b0;
      if (wr_pend_reg) begin
        case (wr_addr_reg)
          `GCI_CTRL_OFS: ctrl_reg <= {24'h00_0000, hwdata[7:0]};
          `GCI_CMD_OFS: panel_reset_reg <= hwdata[0];
          `GCI_LSTMO_OFS: ls_tmo_reg <= hwdata[7:0];
          default: ;
        endcase
      end
    end
  end

  // ============================================================
  // One-second tick
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt_reg <= '0;
    end else if (tick) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 1'b1;
    end
  end
  assign tick = (tick_cnt_reg == TW'(TICK_CYCLES - 1));

  // ============================================================
  // Fault latches
  assign freset_ok = gci_rise(in_db[`GCI_IN_FRESET], freset_prev_reg) & ~in_db[`GCI_IN_RSTART];
  assign cf_gate = ~({4{dormant}} & `GCI_CF_WAKE_MASK);

  always_comb begin
    status_set[0] = in_db[`GCI_IN_ESTOP];
    status_set[4:1] = cf_db & ~cf_sd_sel & cf_gate;
    status_set[8:5] = cf_db & cf_sd_sel & cf_gate;
    status_set[9] = in_db[`GCI_IN_LFUEL] & ~dormant;
    status_set[10] = in_db[`GCI_IN_RUPT];
    status_set[11] = ls_set;
    status_clr[0] = panel_reset_reg;
    status_clr[11:1] = {11{freset_ok}};
  end

  // A set in the same cycle as its clear wins, so no fault is lost.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_reg <= 12'h000;
      freset_prev_reg <= 1'b0;
    end else begin
      status_reg <= status_set | (status_reg & ~status_clr);
      freset_prev_reg <= in_db[`GCI_IN_FRESET];
    end
  end

  // ============================================================
  // Lead-start pulse watchdog
  assign ls_active = (setup_sel != `GCI_SETUP_SINGLE);
  assign ls_set = ls_active & (ls_tmo_reg != 8'h00) & (ls_sec_reg >= ls_tmo_reg);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ls_sec_reg <= 8'h00;
      ls_prev_reg <= 1'b0;
    end else begin
      ls_prev_reg <= in_db[`GCI_IN_LSHI];
      if (!ls_active || gci_rise(in_db[`GCI_IN_LSHI], ls_prev_reg)) begin
        ls_sec_reg <= 8'h00;
      end else if (tick && ls_sec_reg != 8'hFF) begin
        ls_sec_reg <= ls_sec_reg + 8'h01;
      end
    end
  end

  // ============================================================
  // Load demand sequence
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ld_state <= LD_OFF;
      cool_sec_reg <= 16'h0000;
    end else if (!load_demand_mode) begin
      ld_state <= LD_OFF;
      cool_sec_reg <= 16'h0000;
    end else begin
      case (ld_state)
        LD_OFF: ld_state <= LD_RAMP;
        LD_RAMP: if (load_at_min) begin
          ld_state <= LD_OPEN;
        end
        LD_OPEN: if (!in_db[`GCI_IN_BPOS]) begin
          ld_state <= LD_COOL;
        end
        LD_COOL: if (tick) begin
          if (cool_sec_reg >= COOLDOWN_S - 16'h0001) begin
            ld_state <= LD_STOP;
          end else begin
            cool_sec_reg <= cool_sec_reg + 16'h0001;
          end
        end
        LD_STOP: ld_state <= LD_STOP;
        default: ld_state <= LD_OFF;
      endcase
    end
  end

  assign ramp_down_req = (ld_state == LD_RAMP);
  assign ld_shutdown = (ld_state == LD_STOP);

  // ============================================================
  // Command outputs
  assign shut_any = in_db[`GCI_IN_ESTOP] | status_reg[0] | (|status_reg[8:5]);
  assign run_ok = ~shut_any & ~ld_shutdown &
                  ((op_sel == `GCI_OP_RUN) | ((op_sel == `GCI_OP_AUTO) & in_db[`GCI_IN_RSTART]));
  assign warn_any = status_reg[9] | status_reg[10] | status_reg[11] | (|status_reg[4:1]);
  // Idle only acts in the manual run position; automatic operation ignores it.
  assign idle_next = in_db[`GCI_IN_IDLE] & (op_sel == `GCI_OP_RUN);
  assign backup_enable = status_reg[11];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      crank_start <= 1'b0;
      shutdown_now <= 1'b0;
      idle_speed <= 1'b0;
      volt_enable <= 1'b0;
      wake_req <= 1'b0;
      warn_contact_no <= 1'b0;
      warn_contact_nc <= 1'b1;
      sync_enable <= 1'b0;
      bkr_close_permit <= 1'b0;
      bkr_open_cmd <= 1'b0;
      util_par_mode <= 1'b0;
      load_demand_mode <= 1'b0;
      kw_setpoint <= 10'h000;
    end else begin
      crank_start <= run_ok;
      shutdown_now <= shut_any;
      idle_speed <= run_ok & idle_next;
      volt_enable <= run_ok & ~idle_next;
      wake_req <= dormant & (in_db[`GCI_IN_LFUEL] | (|(cf_db & `GCI_CF_WAKE_MASK)));
      warn_contact_no <= warn_any;
      warn_contact_nc <= ~warn_any;
      sync_enable <= (setup_sel == `GCI_SETUP_SINGLE) & in_db[`GCI_IN_LSHI];
      bkr_close_permit <= ~in_db[`GCI_IN_BINH] & ~shut_any & (ld_state == LD_OFF) &
                          ~((setup_sel == `GCI_SETUP_SINGLE) & ~in_db[`GCI_IN_LDEM]);
      bkr_open_cmd <= (in_db[`GCI_IN_BINH] & in_db[`GCI_IN_BPOS]) | (ld_state == LD_OPEN);
      util_par_mode <= in_db[`GCI_IN_UPGND] & in_db[`GCI_IN_UPHI];
      load_demand_mode <= in_db[`GCI_IN_LDEM] & (setup_sel == `GCI_SETUP_MULTI) &
                          (op_sel == `GCI_OP_AUTO);
      kw_setpoint <= util_par_mode ? load_set_code : 10'h000;
    end
  end

  // ============================================================
  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence ld_at_min_s;
    ld_state == LD_RAMP && load_at_min && load_demand_mode;
  endsequence
  sequence ld_opened_s;
    ld_state == LD_OPEN && !in_db[`GCI_IN_BPOS] && load_demand_mode;
  endsequence

  start_auto_a: assert property (op_sel == `GCI_OP_AUTO && in_db[`GCI_IN_RSTART] && !shut_any && !ld_shutdown
    |=> crank_start) else $error("auto start not commanded");
  reset_refused_a: assert property (in_db[`GCI_IN_RSTART] |=> (($past(status_reg) & ~status_reg) == 12'h000))
    else $error("fault cleared while remote start grounded");
  estop_now_a: assert property (in_db[`GCI_IN_ESTOP] |=> shutdown_now && !crank_start)
    else $error("emergency stop not immediate");
  cf_alarm_a: assert property (cf_db[0] && !cf_sd_sel[0] |=> status_reg[1] && !status_reg[5])
    else $error("customer fault alarm not raised");
  reset_clear_a: assert property (freset_ok && cf_db == 4'h0 && !in_db[`GCI_IN_RUPT]
    |=> status_reg[4:1] == 4'h0 && status_reg[8:5] == 4'h0 && status_reg[10] == 1'b0)
    else $error("fault reset did not clear");
  idle_volt_a: assert property (idle_speed |-> !volt_enable) else $error("voltage on at idle");
  wake_first_a: assert property (in_db[`GCI_IN_LFUEL] && dormant && !status_reg[9] |=> wake_req && !status_reg[9])
    else $error("low fuel raised before wake");
  warn_contact_a: assert property (warn_any |=> warn_contact_no && !warn_contact_nc)
    else $error("warning contact not driven");
  estop_hold_a: assert property (status_reg[0] && !panel_reset_reg |=> status_reg[0])
    else $error("emergency stop cleared remotely");
  util_mode_a: assert property (util_par_mode |-> $past(in_db[`GCI_IN_UPGND]) && $past(in_db[`GCI_IN_UPHI]))
    else $error("utility mode without both inputs");
  ld_seq_a: assert property (ld_at_min_s |=> ld_state == LD_OPEN)
    else $error("load demand sequence stalled");
  ld_cool_a: assert property (ld_opened_s |=> ld_state == LD_COOL)
    else $error("cool-down not entered after breaker opened");
  inhibit_a: assert property (in_db[`GCI_IN_BINH] |=> !bkr_close_permit)
    else $error("breaker close not inhibited");
endmodule

// file: bench/gci_switches.sv
// Customer-side model: switches, relays and sensors wired to the input pins.
// Assumes act uses the INPUT register bit order; a set bit means the contact is made.
`timescale 1ns/1ps
`include "gci_regs.svh"
module gci_switches (
  input wire logic [15:0] act,
  output logic remote_start_n,
  output logic estop_n,
  output logic [3:0] cust_fault_n,
  output logic fault_reset_n,
  output logic engine_idle_n,
  output logic low_fuel_n,
  output logic rupture_basin_n,
  output logic util_par_gnd_n,
  output logic util_par_hi,
  output logic lead_start_hi,
  output logic ld_demand_n,
  output logic bkr_inhibit_n,
  output logic bkr_pos_n
);
  // ============================================================
  // Contact pins
  // An open contact is pulled up, so released pins read high, never the last value.
  assign remote_start_n = ~act[`GCI_IN_RSTART];
  assign estop_n = ~act[`GCI_IN_ESTOP];
  assign cust_fault_n = ~act[`GCI_IN_CF_LSB+3:`GCI_IN_CF_LSB];
  assign fault_reset_n = ~act[`GCI_IN_FRESET];
  assign engine_idle_n = ~act[`GCI_IN_IDLE];
  assign low_fuel_n = ~act[`GCI_IN_LFUEL];
  assign rupture_basin_n = ~act[`GCI_IN_RUPT];
  assign util_par_gnd_n = ~act[`GCI_IN_UPGND];
  assign ld_demand_n = ~act[`GCI_IN_LDEM];
  assign bkr_inhibit_n = ~act[`GCI_IN_BINH];
  assign bkr_pos_n = ~act[`GCI_IN_BPOS];
  // ============================================================
  // High-level pins
  assign util_par_hi = act[`GCI_IN_UPHI];
  assign lead_start_hi = act[`GCI_IN_LSHI];
endmodule

// file: bench/tb_genset_customer_input_handler.sv
// Self-checking bench for gci_top with a customer switch model.
// Assumes short simulation counts: 50-cycle tick, 4-cycle debounce, 2-tick cool-down.
`timescale 1ns/1ps
`include "gci_regs.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fails++; $display("ERROR %0t mismatch got %0h expected %0h", $time, (g), (e)); end end
module tb_genset_customer_input_handler;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, dormant, load_at_min;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [9:0] load_set_code, kw_setpoint;
  logic [15:0] act;
  logic [3:0] cust_fault_n;
  logic remote_start_n, estop_n, fault_reset_n, engine_idle_n, low_fuel_n, rupture_basin_n;
  logic util_par_gnd_n, util_par_hi, lead_start_hi, ld_demand_n, bkr_inhibit_n, bkr_pos_n;
  logic crank_start, shutdown_now, idle_speed, volt_enable, wake_req, warn_contact_no, warn_contact_nc;
  logic sync_enable, backup_enable, bkr_close_permit, bkr_open_cmd, util_par_mode;
  logic load_demand_mode, ramp_down_req, ld_shutdown;
  int fails, num_checks;
  // ============================================================
  // Design and switch model
  gci_top #(.TICK_CYCLES(50), .DB_CYCLES(4), .COOLDOWN_S(16'h0002)) u_dut (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .remote_start_n,
    .estop_n, .cust_fault_n, .fault_reset_n, .engine_idle_n, .low_fuel_n, .rupture_basin_n, .util_par_gnd_n,
    .util_par_hi, .lead_start_hi, .ld_demand_n, .bkr_inhibit_n, .bkr_pos_n, .dormant, .load_at_min,
    .load_set_code, .crank_start, .shutdown_now, .idle_speed, .volt_enable, .wake_req, .warn_contact_no,
    .warn_contact_nc, .sync_enable, .backup_enable, .bkr_close_permit, .bkr_open_cmd, .util_par_mode,
    .load_demand_mode, .ramp_down_req, .ld_shutdown, .kw_setpoint);
  gci_switches u_sw (.act, .remote_start_n, .estop_n, .cust_fault_n, .fault_reset_n, .engine_idle_n,
    .low_fuel_n, .rupture_basin_n, .util_par_gnd_n, .util_par_hi, .lead_start_hi, .ld_demand_n,
    .bkr_inhibit_n, .bkr_pos_n);
  // ============================================================
  // Helpers
  task automatic wt(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // Holds each phase until hready is seen high; read data is taken at the data-phase edge.
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h000000, a};
    @(posedge hclk); while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    @(posedge hclk); while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task automatic ctrl(input logic [1:0] op, input logic [1:0] su, input logic [3:0] fs);
    bus(1'b1, `GCI_CTRL_OFS, {24'h000000, fs, su, op});
  endtask
  // Pins need DB_CYCLES+2 stable cycles; 14 leaves margin for the flag and output stages.
  task pin(input int b, input logic v);
    act[b] <= v; wt(14);
  endtask
  task automatic frst();
    pin(`GCI_IN_FRESET, 1'b1); pin(`GCI_IN_FRESET, 1'b0);
  endtask
  task automatic results();
    if (fails == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ============================================================
  // Scenarios
  task automatic t_reset();
    `CHK(warn_contact_nc, 1'b1)
    `CHK(hresp, 1'b0)
    `CHK({crank_start, shutdown_now, warn_contact_no, backup_enable}, 4'h0)
    bus(1'b0, `GCI_CTRL_OFS, 32'h0); `CHK(rd, `GCI_CTRL_RST)
    bus(1'b0, `GCI_LSTMO_OFS, 32'h0); `CHK(rd, 32'h0000000A)
    bus(1'b0, 8'h40, 32'h0); `CHK(rd, 32'h00000000)
    bus(1'b1, `GCI_LSTMO_OFS, 32'h0); // Watchdog off until its own scenario.
  endtask
  task automatic t_start();
    act[`GCI_IN_ESTOP] <= 1'b1; wt(2); pin(`GCI_IN_ESTOP, 1'b0);
    `CHK(shutdown_now, 1'b0)
    pin(`GCI_IN_RSTART, 1'b1); `CHK(crank_start, 1'b0)
    bus(1'b0, `GCI_INPUT_OFS, 32'h0); `CHK(rd[`GCI_IN_RSTART], 1'b1)
    ctrl(`GCI_OP_AUTO, `GCI_SETUP_NONE, 4'h0); wt(4); `CHK(crank_start, 1'b1)
    pin(`GCI_IN_RSTART, 1'b0);
  endtask
  task automatic t_estop();
    pin(`GCI_IN_ESTOP, 1'b1); `CHK(shutdown_now, 1'b1)
    pin(`GCI_IN_ESTOP, 1'b0); frst();
    bus(1'b0, `GCI_STATUS_OFS, 32'h0); `CHK(rd[0], 1'b1)
    bus(1'b1, `GCI_CMD_OFS, 32'h1); wt(4); `CHK(shutdown_now, 1'b0)
    bus(1'b0, `GCI_STATUS_OFS, 32'h0); `CHK(rd, 32'h0)
  endtask
  task automatic t_fault();
    ctrl(`GCI_OP_AUTO, `GCI_SETUP_NONE, 4'h8);
    pin(`GCI_IN_CF_LSB, 1'b1); pin(`GCI_IN_CF_LSB + 3, 1'b1);
    pin(`GCI_IN_CF_LSB, 1'b0); pin(`GCI_IN_CF_LSB + 3, 1'b0);
    `CHK(shutdown_now, 1'b1)
    bus(1'b0, `GCI_STATUS_OFS, 32'h0); `CHK(rd, 32'h00000102)
    pin(`GCI_IN_RSTART, 1'b1); frst();
    bus(1'b0, `GCI_STATUS_OFS, 32'h0); `CHK(rd, 32'h00000102)
    pin(`GCI_IN_RSTART, 1'b0); frst();
    bus(1'b0, `GCI_STATUS_OFS, 32'h0); `CHK(rd, 32'h0)
  endtask
  task automatic t_fuel();
    dormant <= 1'b1; pin(`GCI_IN_LFUEL, 1'b1); `CHK(wake_req, 1'b1)
    bus(1'b0, `GCI_STATUS_OFS, 32'h0); `CHK(rd[9], 1'b0)
    dormant <= 1'b0; pin(`GCI_IN_RUPT, 1'b1);
    bus(1'b0, `GCI_STATUS_OFS, 32'h0); `CHK(rd[10:9], 2'h3)
    `CHK({warn_contact_no, warn_contact_nc}, 2'h2)
    pin(`GCI_IN_LFUEL, 1'b0); pin(`GCI_IN_RUPT, 1'b0); frst();
    `CHK({warn_contact_no, warn_contact_nc}, 2'h1)
  endtask
  task automatic t_idle();
    ctrl(`GCI_OP_RUN, `GCI_SETUP_NONE, 4'h0); pin(`GCI_IN_IDLE, 1'b1);
    `CHK({idle_speed, volt_enable}, 2'h2)
    ctrl(`GCI_OP_AUTO, `GCI_SETUP_NONE, 4'h0); pin(`GCI_IN_RSTART, 1'b1);
    `CHK({idle_speed, volt_enable}, 2'h1)
    pin(`GCI_IN_IDLE, 1'b0); pin(`GCI_IN_RSTART, 1'b0);
  endtask
  task automatic t_util();
    load_set_code <= 10'h2A5; pin(`GCI_IN_UPGND, 1'b1);
    `CHK(util_par_mode, 1'b0)
    `CHK(kw_setpoint, 10'h000)
    pin(`GCI_IN_UPHI, 1'b1); `CHK(util_par_mode, 1'b1)
    `CHK(kw_setpoint, 10'h2A5)
    bus(1'b0, `GCI_OUTPUT_OFS, 32'h0); `CHK(rd[13], 1'b1)
    pin(`GCI_IN_UPGND, 1'b0); pin(`GCI_IN_UPHI, 1'b0); `CHK(util_par_mode, 1'b0)
  endtask
  task automatic t_brk();
    ctrl(`GCI_OP_AUTO, `GCI_SETUP_SINGLE, 4'h0); wt(4); `CHK(bkr_close_permit, 1'b0)
    pin(`GCI_IN_LDEM, 1'b1); `CHK(bkr_close_permit, 1'b1)
    `CHK(load_demand_mode, 1'b0)
    pin(`GCI_IN_LSHI, 1'b1); `CHK(sync_enable, 1'b1)
    pin(`GCI_IN_BINH, 1'b1); `CHK(bkr_close_permit, 1'b0)
    pin(`GCI_IN_BPOS, 1'b1); `CHK(bkr_open_cmd, 1'b1)
    bus(1'b0, `GCI_INPUT_OFS, 32'h0); `CHK(rd[15:14], 2'h3)
    act <= 16'h0; wt(14); `CHK({bkr_open_cmd, sync_enable}, 2'h0)
  endtask
  task automatic t_ld();
    ctrl(`GCI_OP_AUTO, `GCI_SETUP_MULTI, 4'h0); pin(`GCI_IN_RSTART, 1'b1); pin(`GCI_IN_BPOS, 1'b1);
    pin(`GCI_IN_LDEM, 1'b1); `CHK({load_demand_mode, ramp_down_req}, 2'h3)
    load_at_min <= 1'b1; wt(4); `CHK(bkr_open_cmd, 1'b1)
    pin(`GCI_IN_BPOS, 1'b0); `CHK({ld_shutdown, crank_start}, 2'h1)
    wt(120); `CHK({ld_shutdown, crank_start}, 2'h2)
    pin(`GCI_IN_LDEM, 1'b0); `CHK(load_demand_mode, 1'b0)
    load_at_min <= 1'b0; act <= 16'h0; wt(14); frst();
  endtask
  task automatic t_lead();
    pin(`GCI_IN_LSHI, 1'b1); pin(`GCI_IN_LSHI, 1'b0); bus(1'b1, `GCI_LSTMO_OFS, 32'h2);
    wt(20); `CHK(backup_enable, 1'b0)
    wt(150); `CHK(backup_enable, 1'b1)
    bus(1'b0, `GCI_STATUS_OFS, 32'h0); `CHK(rd[11], 1'b1)
  endtask
  // ============================================================
  // Clock, reset, sequence and watchdog
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  initial begin
    fails = 0; num_checks = 0; hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0;
    hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0; act = 16'h0; dormant = 1'b0; load_at_min = 1'b0;
    load_set_code = 10'h000;
    wt(16); hresetn <= 1'b1; wt(1);
    t_reset(); t_start(); t_estop(); t_fault(); t_fuel(); t_idle(); t_util(); t_brk(); t_ld(); t_lead();
    results();
  end
  initial begin
    wt(20000); fails++; results();
  end
endmodule
